// ===== shared/jfp_pkg.sv
// constants and types for the test-port flash programming block
package jfp_pkg;
    // instruction codes
    localparam logic [3:0] IR_CORE_RESET = 4'hC;
    localparam logic [3:0] IR_UNLOCK = 4'h4;
    localparam logic [3:0] IR_COMMAND = 4'h5;
    localparam logic [3:0] IR_PAGE_LOAD = 4'h6;
    localparam logic [3:0] IR_PAGE_READ = 4'h7;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // data register widths and signature
    localparam int UNLOCK_W = 16;
    localparam int CMD_W = 15;
    localparam int BYTE_W = 8;
    localparam logic [15:0] UNLOCK_SIG = 16'hA370;
    localparam logic [14:0] CMD_RESET = 15'h0000;
    // timing
    localparam int CLK_MHZ = 50;
    localparam int DISABLE_CLR_CLKS = 2;
    localparam int PGLD_LIMIT_TCK = 11;
    localparam int TCK_NS = 160;
    localparam int PGLD_LIMIT_CYC = (PGLD_LIMIT_TCK * TCK_NS * CLK_MHZ) / 1000;
    // register map, byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CMD = 4'h8;
    localparam int CTRL_DISABLE_BIT = 0;
    localparam int ST_PORT_EN = 0;
    localparam int ST_PROG_MODE = 1;
    localparam int ST_CORE_RST = 2;
    localparam int ST_IR_LSB = 4;
    localparam logic CTRL_DISABLE_RST = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // tap controller states
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3,
        TAP_CAP_DR = 4'h2, TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7,
        TAP_PA_DR = 4'h5, TAP_EX2_DR = 4'h4, TAP_UPD_DR = 4'hC,
        TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SH_IR = 4'hE,
        TAP_EX1_IR = 4'hA, TAP_PA_IR = 4'hB, TAP_EX2_IR = 4'h9,
        TAP_UPD_IR = 4'h8
    } jfp_tap_t;
    // page buffer write carrier
    typedef struct packed {
        logic hi;
        logic [7:0] data;
    } jfp_pgbuf_t;
endpackage

// ===== hw/jfp_top.sv
// test-port flash programming logic with axi4-lite status registers
`timescale 1ns/1ps
module jfp_top
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // test port pins
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    // chip straps and pins
    input wire logic i_test_port_enable_fuse,
    input wire logic i_ext_rst_n,
    // flash side
    input wire logic [14:0] i_cmd_result,
    input wire logic [15:0] i_flash_word,
    output logic [14:0] o_flash_cmd,
    output logic o_cmd_exec,
    output logic o_pgbuf_we,
    output jfp_pkg::jfp_pgbuf_t o_pgbuf,
    output logic o_pc_inc,
    output logic o_core_rst,
    output logic o_prog_mode,
    output logic o_port_en,
    // axi4-lite slave
    input wire logic [3:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [3:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);
    logic [2:0] tck_sync_q;
    logic [1:0] tms_sync_q, tdi_sync_q, fuse_sync_q, xrst_sync_q;
    logic tck_rise, tck_fall, tms_s, tdi_s;
    jfp_pkg::jfp_tap_t tap_q, tap_d;
    logic [3:0] ir_q, ir_sr_q;
    logic byp_q, rst_reg_q;
    logic [15:0] en_sr_q;
    logic [14:0] cmd_sr_q;
    logic exec_pend_q, pl_hi_q, pl_first_q, pr_hi_q, wr_pend_q;
    logic [7:0] tmp_q;
    logic tdo_d, disable_q;
    logic [1:0] xrst_cnt_q;
    logic aw_got_q, w_got_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_strb0_q;

    // two-flop synchronisers on every pin, third tck flop for edges
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            tck_sync_q <= 3'h0;
            tms_sync_q <= 2'h3;
            tdi_sync_q <= 2'h3;
            fuse_sync_q <= 2'h0;
            xrst_sync_q <= 2'h3;
        end
        else
        begin
            tck_sync_q <= {tck_sync_q[1:0], i_tck};
            tms_sync_q <= {tms_sync_q[0], i_tms};
            tdi_sync_q <= {tdi_sync_q[0], i_tdi};
            fuse_sync_q <= {fuse_sync_q[0], i_test_port_enable_fuse};
            xrst_sync_q <= {xrst_sync_q[0], i_ext_rst_n};
        end
    end
    assign tck_rise = tck_sync_q[1] & ~tck_sync_q[2];
    assign tck_fall = ~tck_sync_q[1] & tck_sync_q[2];
    assign tms_s = tms_sync_q[1];
    assign tdi_s = tdi_sync_q[1];

    // disable bit: software sets, external reset low clears it
    // clear after two
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            disable_q <= jfp_pkg::CTRL_DISABLE_RST;
            xrst_cnt_q <= 2'h0;
        end
        else
        begin
            if (xrst_sync_q[1] || !disable_q)
                xrst_cnt_q <= 2'h0;
            else if (xrst_cnt_q != 2'(jfp_pkg::DISABLE_CLR_CLKS))
                xrst_cnt_q <= xrst_cnt_q + 2'h1;
            if (xrst_cnt_q == 2'(jfp_pkg::DISABLE_CLR_CLKS - 1))
                disable_q <= 1'b0;
            else if (aw_got_q && w_got_q && !o_bvalid && w_strb0_q
                     && aw_addr_q == jfp_pkg::ADDR_CTRL)
                disable_q <= w_data_q[jfp_pkg::CTRL_DISABLE_BIT];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            o_port_en <= 1'b0;
        else
            o_port_en <= fuse_sync_q[1] & ~disable_q;
    end

    // tap next state
    always_comb
    begin
        tap_d = tap_q;
        unique case (tap_q)
            jfp_pkg::TAP_RESET: tap_d = tms_s ? jfp_pkg::TAP_RESET
                                              : jfp_pkg::TAP_IDLE;
            jfp_pkg::TAP_IDLE: tap_d = tms_s ? jfp_pkg::TAP_SEL_DR
                                             : jfp_pkg::TAP_IDLE;
            jfp_pkg::TAP_SEL_DR: tap_d = tms_s ? jfp_pkg::TAP_SEL_IR
                                               : jfp_pkg::TAP_CAP_DR;
            jfp_pkg::TAP_CAP_DR: tap_d = tms_s ? jfp_pkg::TAP_EX1_DR
                                               : jfp_pkg::TAP_SH_DR;
            jfp_pkg::TAP_SH_DR: tap_d = tms_s ? jfp_pkg::TAP_EX1_DR
                                              : jfp_pkg::TAP_SH_DR;
            jfp_pkg::TAP_EX1_DR: tap_d = tms_s ? jfp_pkg::TAP_UPD_DR
                                               : jfp_pkg::TAP_PA_DR;
            jfp_pkg::TAP_PA_DR: tap_d = tms_s ? jfp_pkg::TAP_EX2_DR
                                              : jfp_pkg::TAP_PA_DR;
            jfp_pkg::TAP_EX2_DR: tap_d = tms_s ? jfp_pkg::TAP_UPD_DR
                                               : jfp_pkg::TAP_SH_DR;
            jfp_pkg::TAP_UPD_DR: tap_d = tms_s ? jfp_pkg::TAP_SEL_DR
                                               : jfp_pkg::TAP_IDLE;
            jfp_pkg::TAP_SEL_IR: tap_d = tms_s ? jfp_pkg::TAP_RESET
                                               : jfp_pkg::TAP_CAP_IR;
            jfp_pkg::TAP_CAP_IR: tap_d = tms_s ? jfp_pkg::TAP_EX1_IR
                                               : jfp_pkg::TAP_SH_IR;
            jfp_pkg::TAP_SH_IR: tap_d = tms_s ? jfp_pkg::TAP_EX1_IR
                                              : jfp_pkg::TAP_SH_IR;
            jfp_pkg::TAP_EX1_IR: tap_d = tms_s ? jfp_pkg::TAP_UPD_IR
                                               : jfp_pkg::TAP_PA_IR;
            jfp_pkg::TAP_PA_IR: tap_d = tms_s ? jfp_pkg::TAP_EX2_IR
                                              : jfp_pkg::TAP_PA_IR;
            jfp_pkg::TAP_EX2_IR: tap_d = tms_s ? jfp_pkg::TAP_UPD_IR
                                               : jfp_pkg::TAP_SH_IR;
            jfp_pkg::TAP_UPD_IR: tap_d = tms_s ? jfp_pkg::TAP_SEL_DR
                                               : jfp_pkg::TAP_IDLE;
        endcase
    end

    // tap state register, held in reset while the port is unusable
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || !o_port_en)
            tap_q <= jfp_pkg::TAP_RESET;
        else if (tck_rise)
            tap_q <= tap_d;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || !o_port_en || tap_q == jfp_pkg::TAP_RESET)
        begin
            ir_q <= jfp_pkg::IR_BYPASS;
            ir_sr_q <= 4'h0;
        end
        else if (tck_rise)
        begin
            if (tap_q == jfp_pkg::TAP_CAP_IR)
                ir_sr_q <= jfp_pkg::IR_CAPTURE;
            else if (tap_q == jfp_pkg::TAP_SH_IR)
                ir_sr_q <= {tdi_s, ir_sr_q[3:1]};
            else if (tap_q == jfp_pkg::TAP_UPD_IR)
                ir_q <= ir_sr_q;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            byp_q <= 1'b0;
        else if (tck_rise && tap_q == jfp_pkg::TAP_CAP_DR)
            byp_q <= 1'b0;
        else if (tck_rise && tap_q == jfp_pkg::TAP_SH_DR)
            byp_q <= tdi_s;
    end

    // reset register shifts in place; not cleared by tap reset
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            rst_reg_q <= 1'b0;
        else if (tck_rise && tap_q == jfp_pkg::TAP_SH_DR
                 && ir_q == jfp_pkg::IR_CORE_RESET)
            rst_reg_q <= tdi_s;
    end

    assign o_core_rst = rst_reg_q;

    // unlock register shift, compare on update
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            en_sr_q <= 16'h0000;
            o_prog_mode <= 1'b0;
        end
        else if (tck_rise && ir_q == jfp_pkg::IR_UNLOCK)
        begin
            if (tap_q == jfp_pkg::TAP_SH_DR)
                en_sr_q <= {tdi_s, en_sr_q[15:1]};
            else if (tap_q == jfp_pkg::TAP_UPD_DR)
                o_prog_mode <= (en_sr_q == jfp_pkg::UNLOCK_SIG);
        end
    end

    // command register and its byte view
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            cmd_sr_q <= jfp_pkg::CMD_RESET;
            o_flash_cmd <= jfp_pkg::CMD_RESET;
        end
        else if (tck_rise && ir_q == jfp_pkg::IR_COMMAND)
        begin
            if (tap_q == jfp_pkg::TAP_CAP_DR)
                cmd_sr_q <= i_cmd_result;
            else if (tap_q == jfp_pkg::TAP_SH_DR)
                cmd_sr_q <= {tdi_s, cmd_sr_q[14:1]};
            else if (tap_q == jfp_pkg::TAP_UPD_DR && o_prog_mode)
                o_flash_cmd <= cmd_sr_q;
        end
        else if (tck_rise && (ir_q == jfp_pkg::IR_PAGE_LOAD
                              || ir_q == jfp_pkg::IR_PAGE_READ))
        begin
            if (tap_q == jfp_pkg::TAP_CAP_DR
                && ir_q == jfp_pkg::IR_PAGE_READ)
                cmd_sr_q[7:0] <= pr_hi_q ? i_flash_word[15:8]
                                         : i_flash_word[7:0];
            else if (tap_q == jfp_pkg::TAP_SH_DR)
                cmd_sr_q[7:0] <= {tdi_s, cmd_sr_q[7:1]};
        end
    end

    // idle entry clocks the applied command
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            exec_pend_q <= 1'b0;
            o_cmd_exec <= 1'b0;
        end
        else
        begin
            o_cmd_exec <= 1'b0;
            // one execute pulse, also when update enters idle
            if (tck_rise && tap_q != jfp_pkg::TAP_IDLE
                && tap_d == jfp_pkg::TAP_IDLE
                && (exec_pend_q || (ir_q == jfp_pkg::IR_COMMAND
                    && o_prog_mode && tap_q == jfp_pkg::TAP_UPD_DR)))
            begin
                exec_pend_q <= 1'b0;
                o_cmd_exec <= 1'b1;
            end
            // update that bypasses idle waits for the next entry
            else if (tck_rise && ir_q == jfp_pkg::IR_COMMAND && o_prog_mode
                     && tap_q == jfp_pkg::TAP_UPD_DR)
                exec_pend_q <= 1'b1;
        end
    end

    // page load/read byte alternation and pc stepping
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            pl_hi_q <= 1'b0;
            pl_first_q <= 1'b1;
            pr_hi_q <= 1'b0;
            wr_pend_q <= 1'b0;
            tmp_q <= 8'h00;
            o_pc_inc <= 1'b0;
            o_pgbuf_we <= 1'b0;
            o_pgbuf <= '0;
        end
        else
        begin
            o_pc_inc <= 1'b0;
            o_pgbuf_we <= 1'b0;
            // write buffered byte one cycle later
            if (wr_pend_q)
            begin
                wr_pend_q <= 1'b0;
                o_pgbuf_we <= 1'b1;
                o_pgbuf.data <= tmp_q;
                o_pgbuf.hi <= ~pl_hi_q;
            end
            if (tck_rise && tap_q == jfp_pkg::TAP_UPD_IR)
            begin
                pl_hi_q <= 1'b0;
                pl_first_q <= 1'b1;
                pr_hi_q <= 1'b0;
            end
            else if (tck_rise && o_prog_mode
                     && ir_q == jfp_pkg::IR_PAGE_LOAD
                     && tap_q == jfp_pkg::TAP_UPD_DR)
            begin
                tmp_q <= cmd_sr_q[7:0];
                wr_pend_q <= 1'b1;
                pl_hi_q <= ~pl_hi_q;
                pl_first_q <= 1'b0;
                o_pc_inc <= ~pl_hi_q & ~pl_first_q;
            end
            else if (tck_rise && o_prog_mode
                     && ir_q == jfp_pkg::IR_PAGE_READ
                     && tap_q == jfp_pkg::TAP_CAP_DR)
            begin
                pr_hi_q <= ~pr_hi_q;
                o_pc_inc <= pr_hi_q;
            end
        end
    end

    // tdo source by selected register
    always_comb
    begin
        if (tap_q == jfp_pkg::TAP_SH_IR)
            tdo_d = ir_sr_q[0];
        else
        begin
            unique case (ir_q)
                jfp_pkg::IR_CORE_RESET: tdo_d = rst_reg_q;
                jfp_pkg::IR_UNLOCK: tdo_d = en_sr_q[0];
                jfp_pkg::IR_COMMAND,
                jfp_pkg::IR_PAGE_LOAD,
                jfp_pkg::IR_PAGE_READ: tdo_d = cmd_sr_q[0];
                default: tdo_d = byp_q;
            endcase
        end
    end

    // tdo changes on falling tck, driven only while shifting
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || !o_port_en)
        begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            o_tdo <= tdo_d;
            o_tdo_oe <= (tap_q == jfp_pkg::TAP_SH_DR)
                        || (tap_q == jfp_pkg::TAP_SH_IR);
        end
    end

    // axi write: address and data in either order, then response
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb0_q <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= jfp_pkg::RESP_OKAY;
        end
        else
        begin
            o_awready <= !aw_got_q && !o_awready && i_awvalid;
            o_wready <= !w_got_q && !o_wready && i_wvalid;
            if (o_awready && i_awvalid)
            begin
                aw_got_q <= 1'b1;
                aw_addr_q <= i_awaddr;
            end
            if (o_wready && i_wvalid)
            begin
                w_got_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb0_q <= i_wstrb[0];
            end
            if (aw_got_q && w_got_q && !o_bvalid)
            begin
                o_bvalid <= 1'b1;
                o_bresp <= (aw_addr_q == jfp_pkg::ADDR_CTRL)
                           ? jfp_pkg::RESP_OKAY : jfp_pkg::RESP_SLVERR;
            end
            else if (o_bvalid && i_bready)
            begin
                o_bvalid <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
        end
    end

    // axi read: control, status and applied command
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= jfp_pkg::RESP_OKAY;
        end
        else
        begin
            o_arready <= !o_rvalid && !o_arready && i_arvalid;
            if (o_arready && i_arvalid)
            begin
                o_rvalid <= 1'b1;
                o_rresp <= jfp_pkg::RESP_OKAY;
                o_rdata <= 32'h0000_0000;
                unique case (i_araddr)
                    jfp_pkg::ADDR_CTRL:
                        o_rdata[jfp_pkg::CTRL_DISABLE_BIT] <= disable_q;
                    jfp_pkg::ADDR_STATUS:
                    begin
                        o_rdata[jfp_pkg::ST_PORT_EN] <= o_port_en;
                        o_rdata[jfp_pkg::ST_PROG_MODE] <= o_prog_mode;
                        o_rdata[jfp_pkg::ST_CORE_RST] <= rst_reg_q;
                        o_rdata[jfp_pkg::ST_IR_LSB +: 4] <= ir_q;
                    end
                    jfp_pkg::ADDR_CMD:
                        o_rdata[14:0] <= o_flash_cmd;
                    default:
                        o_rresp <= jfp_pkg::RESP_SLVERR;
                endcase
            end
            else if (o_rvalid && i_rready)
                o_rvalid <= 1'b0;
        end
    end

    // checks
    sequence s_upd_unlock;
        tck_rise && tap_q == jfp_pkg::TAP_UPD_DR
        && ir_q == jfp_pkg::IR_UNLOCK;
    endsequence
    sequence s_pgld_upd;
        tck_rise && o_prog_mode && ir_q == jfp_pkg::IR_PAGE_LOAD
        && tap_q == jfp_pkg::TAP_UPD_DR;
    endsequence
    property p_unlock;
        @(posedge i_clock) disable iff (i_sys_rst)
        s_upd_unlock |=> o_prog_mode
            == ($past(en_sr_q) == jfp_pkg::UNLOCK_SIG);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("programming mode not set by signature compare");
    property p_rst_shift;
        @(posedge i_clock) disable iff (i_sys_rst)
        tck_rise && tap_q == jfp_pkg::TAP_SH_DR
        && ir_q == jfp_pkg::IR_CORE_RESET |=> o_core_rst == $past(tdi_s);
    endproperty
    a_rst_shift: assert property (p_rst_shift)
        else $error("core reset does not follow reset register");
    property p_exec_once;
        @(posedge i_clock) disable iff (i_sys_rst)
        o_cmd_exec |=> !o_cmd_exec && tap_q == jfp_pkg::TAP_IDLE;
    endproperty
    a_exec_once: assert property (p_exec_once)
        else $error("command execute not a single idle pulse");
    property p_pgld_write;
        @(posedge i_clock) disable iff (i_sys_rst)
        s_pgld_upd |-> ##2 o_pgbuf_we
            && o_pgbuf.data == $past(cmd_sr_q[7:0], 2);
    endproperty
    a_pgld_write: assert property (p_pgld_write)
        else $error("page buffer write late or wrong byte");
    property p_pgld_alt;
        @(posedge i_clock) disable iff (i_sys_rst)
        s_pgld_upd |-> ##2 o_pgbuf.hi == $past(pl_hi_q, 2);
    endproperty
    a_pgld_alt: assert property (p_pgld_alt)
        else $error("page load byte order broken");
    property p_pgld_inc;
        @(posedge i_clock) disable iff (i_sys_rst)
        s_pgld_upd |=> o_pc_inc == (!$past(pl_hi_q) && !$past(pl_first_q));
    endproperty
    a_pgld_inc: assert property (p_pgld_inc)
        else $error("page load pc step wrong");
    property p_pgrd_inc;
        @(posedge i_clock) disable iff (i_sys_rst)
        tck_rise && o_prog_mode && ir_q == jfp_pkg::IR_PAGE_READ
        && tap_q == jfp_pkg::TAP_CAP_DR |=> o_pc_inc == $past(pr_hi_q);
    endproperty
    a_pgrd_inc: assert property (p_pgrd_inc)
        else $error("page read pc step wrong");
    property p_dis_clr;
        @(posedge i_clock) disable iff (i_sys_rst)
        disable_q && !xrst_sync_q[1] && xrst_cnt_q == 2'h0
        ##1 !xrst_sync_q[1] |=> !disable_q;
    endproperty
    a_dis_clr: assert property (p_dis_clr)
        else $error("disable bit not cleared after two clocks");
    property p_port_gate;
        @(posedge i_clock) disable iff (i_sys_rst)
        !o_port_en |=> tap_q == jfp_pkg::TAP_RESET && !o_tdo_oe;
    endproperty
    a_port_gate: assert property (p_port_gate)
        else $error("test port active while disabled");
endmodule // jfp_top

// ===== tb/jfp_prog_model.sv
// test-port programmer model driving tck, tms and tdi and sampling tdo
`timescale 1ns/1ps
module jfp_prog_model
(
    // test port pins
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo
);
    // tck stands low between frames
    initial
    begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // slow tck
    // one 160 ns tck period, tdo taken just before the rise
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms <= tms;
        o_tdi <= tdi;
        #80 tdo = i_tdo;
        o_tck <= 1'b1;
        #80 o_tck <= 1'b0;
    endtask
    // idle to idle through one dr or ir scan of n bits
    task automatic scan(input logic ir, input logic [15:0] v, input int n,
        output logic [15:0] r);
        logic t;
        r = '0;
        tick(1'b1, 1'b0, t);
        if (ir)
            tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
        tick(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, v[i], t);
            r[i] = t;
        end
        tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
    endtask
endmodule // jfp_prog_model

// ===== tb/jfp_top_tb.sv
// self-checking bench for the test-port programming block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
    n_mismatch++; $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module jfp_top_tb;
    logic i_clock, i_sys_rst, i_tck, i_tms, i_tdi, i_ext_rst_n, t;
    logic i_test_port_enable_fuse, i_awvalid, i_wvalid, i_bready;
    logic i_arvalid, i_rready, o_tdo, o_tdo_oe, o_cmd_exec, o_pgbuf_we;
    logic o_pc_inc, o_core_rst, o_prog_mode, o_port_en, o_awready;
    logic o_wready, o_bvalid, o_arready, o_rvalid;
    logic [14:0] i_cmd_result, o_flash_cmd;
    logic [15:0] i_flash_word, r, w;
    logic [3:0] i_awaddr, i_wstrb, i_araddr;
    logic [31:0] i_wdata, o_rdata, d;
    logic [1:0] o_bresp, o_rresp, rs;
    jfp_pkg::jfp_pgbuf_t o_pgbuf;
    int n_tests, n_mismatch, n_exec, n_we, n_pc, e, p;
    jfp_top u_jfp_top (.i_clock, .i_sys_rst, .i_tck, .i_tms, .i_tdi, .o_tdo,
        .o_tdo_oe, .i_test_port_enable_fuse, .i_ext_rst_n, .i_cmd_result,
        .i_flash_word, .o_flash_cmd, .o_cmd_exec, .o_pgbuf_we, .o_pgbuf,
        .o_pc_inc, .o_core_rst, .o_prog_mode, .o_port_en, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
        .o_rdata, .o_rresp, .o_rvalid, .i_rready);
    jfp_prog_model u_jfp_prog_model (.o_tck(i_tck), .o_tms(i_tms),
        .o_tdi(i_tdi), .i_tdo(o_tdo));
    // 50 MHz clock
    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // pulse counters
    always @(posedge i_clock)
    begin
        n_exec += o_cmd_exec;
        n_we += o_pgbuf_we;
        n_pc += o_pc_inc;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // expected page buffer entry: low byte on even updates
    function automatic logic [8:0] exp_pg(input int k, input logic [15:0] v);
        return {k[0], v[7:0]};
    endfunction
    // scan, then let the synchronisers settle
    task automatic sc(input logic ir, input logic [15:0] v, input int n);
        u_jfp_prog_model.scan(ir, v, n, r);
        repeat (8) @(posedge i_clock);
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clock);
        {i_awaddr, i_wdata, i_wstrb} <= {a, v, 4'hF};
        {i_awvalid, i_wvalid, i_bready} <= 3'h7;
        do
        begin
            @(posedge i_clock);
            if (o_awready)
                i_awvalid <= 1'b0;
            if (o_wready)
                i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        rs = o_bresp;
        i_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        @(posedge i_clock);
        {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
        do
        begin
            @(posedge i_clock);
            if (o_arready)
                i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        {d, rs} = {o_rdata, o_rresp};
        i_rready <= 1'b0;
    endtask
    // watchdog
    initial
    begin
        #1000000 n_mismatch++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        void'($urandom(32'h423E));
        {i_sys_rst, i_test_port_enable_fuse, i_ext_rst_n} = 3'h7;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
        {i_awaddr, i_araddr, i_wstrb, i_wdata} = '0;
        {i_cmd_result, i_flash_word} = '0;
        repeat (10) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        repeat (6) @(posedge i_clock);
        axi_rd(jfp_pkg::ADDR_STATUS);
        `CHK("port_en", 1'b1, d[0])
        axi_rd(4'hC);
        `CHK("unmapped", jfp_pkg::RESP_SLVERR, rs)
        u_jfp_prog_model.tick(1'b0, 1'b0, t);
        sc(1'b1, 16'h000F, 4);
        `CHK("ir capture", 4'h1, r[3:0])
        sc(1'b0, 16'h0001, 2);
        `CHK("bypass", 2'h2, r[1:0])
        sc(1'b1, 16'h000C, 4);
        sc(1'b0, 16'h0001, 1);
        `CHK("core_rst", 1'b1, o_core_rst)
        sc(1'b1, 16'h0004, 4);
        sc(1'b0, jfp_pkg::UNLOCK_SIG ^ 16'h0100, 16);
        `CHK("bad sig", 1'b0, o_prog_mode)
        sc(1'b0, jfp_pkg::UNLOCK_SIG, 16);
        `CHK("prog_mode", 1'b1, o_prog_mode)
        sc(1'b1, 16'h0005, 4);
        for (int k = 0; k < 2; k++)
        begin
            w = $urandom;
            @(posedge i_clock);
            i_cmd_result <= w[14:0];
            e = n_exec;
            sc(1'b0, w ^ 16'h5A5A, 15);
            `CHK("result", w[14:0], r[14:0])
            `CHK("cmd", w[14:0] ^ 15'h5A5A, o_flash_cmd)
            `CHK("exec", e + 1, n_exec)
        end
        axi_rd(jfp_pkg::ADDR_CMD);
        `CHK("cmd reg", {17'h0, w[14:0] ^ 15'h5A5A}, d)
        sc(1'b1, 16'h0006, 4);
        {e, p} = {n_we, n_pc};
        for (int k = 0; k < 4; k++)
        begin
            w = $urandom;
            sc(1'b0, w, 8);
            `CHK("pgbuf", exp_pg(k, w), o_pgbuf)
        end
        `CHK("writes", e + 4, n_we)
        `CHK("pc load", p + 1, n_pc)
        sc(1'b1, 16'h0007, 4);
        w = $urandom;
        @(posedge i_clock);
        i_flash_word <= w;
        p = n_pc;
        sc(1'b0, 16'h0000, 8);
        `CHK("low", w[7:0], r[7:0])
        sc(1'b0, 16'h0000, 8);
        `CHK("high", w[15:8], r[7:0])
        `CHK("pc read", p + 1, n_pc)
        axi_wr(jfp_pkg::ADDR_CTRL, 32'h1);
        `CHK("bresp", jfp_pkg::RESP_OKAY, rs)
        repeat (6) @(posedge i_clock);
        `CHK("disabled", 1'b0, o_port_en)
        `CHK("oe off", 1'b0, o_tdo_oe)
        i_ext_rst_n <= 1'b0;
        repeat (8) @(posedge i_clock);
        `CHK("reenabled", 1'b1, o_port_en)
        give_verdict();
    end
endmodule // jfp_top_tb
